// file: devctl_pkg.sv
// package: device control and status register layout, reset values and carriers
package devctl_pkg;
  localparam int num_funcs = 2;
  localparam logic [7:0] devctl_off = 8'he8;
  localparam logic [7:0] devsts_off = 8'hea;
  // device control field positions
  localparam int ctl_mrrs_lo = 12;
  localparam int ctl_mrrs_hi = 14;
  localparam int ctl_nosnoop = 11;
  localparam int ctl_auxpm = 10;
  localparam int ctl_phantom = 9;
  localparam int ctl_exttag = 8;
  localparam int ctl_mps_lo = 5;
  localparam int ctl_mps_hi = 7;
  localparam int ctl_relord = 4;
  localparam int ctl_ur_en = 3;
  localparam int ctl_fatal_en = 2;
  localparam int ctl_nonfatal_en = 1;
  localparam int ctl_corr_en = 0;
  // device status field positions
  localparam int sts_trans_pend = 5;
  localparam int sts_aux_det = 4;
  // masks of writable bits
  localparam logic [15:0] ctl_wr_mask = 16'h7fff;
  localparam logic [15:0] sts_w1c_mask = 16'h000f;
  localparam logic [2:0] mrrs_512 = 3'h2;
  localparam logic [2:0] mrrs_128 = 3'h0;
  localparam logic [2:0] mrrs_max_code = 3'h4;
  localparam logic [2:0] mps_128 = 3'h0;
  localparam logic [15:0] ctl_rst_base = 16'h0810;
  localparam logic [3:0] err_none = 4'h0;
  localparam logic [11:0] bytes_128 = 12'h080;

  typedef struct packed {
    logic ur;
    logic fatal;
    logic nonfatal;
    logic corr;
  } err_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [$clog2(num_funcs)-1:0] func;
    logic [15:0] wdata;
  } cfg_req_s;
endpackage

// file: devctl_regs.sv
// device control / device status register bank, one pair per function
// Overview of operation
// - read request size code 0..4 means 128..2048 bytes; 5..7 reserved
// - read request size resets to 512 bytes for network, 128 otherwise
// - no-snoop enable resets to one, also gated by snoop suppress bits
// - aux power drawn when any function enables it, regardless of aux signal
// - phantom and extended tag bits reset zero and have no effect
// - payload size resets to 128 bytes; receiver accepts up to programmed size
// - transmitter never emits payload larger than programmed size
// - relaxed ordering enable resets to one and permits relaxed writes
// - four error reporting enables at bits 3..0 reset to zero
// - per-function 16-bit status register at offset ea
// - transaction pending reads one while transactions are outstanding
// - unsupported request detected set in every function on ur_received, in one function only on its own err_detect ur
// - detected error bits reset zero, set on detection, write-one clears
// - reserved bits read zero and ignore writes
// - per-function 16-bit read-write control register at offset e8
`timescale 1ns/1ps
`default_nettype none
module devctl_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pwr_good_rst_n,
  input wire devctl_pkg::cfg_req_s cfg_req,
  output logic [15:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic [devctl_pkg::num_funcs-1:0] is_lan_func,
  input wire logic [devctl_pkg::num_funcs-1:0] pending,
  input wire logic aux_strap,
  input wire logic ur_received,
  input wire devctl_pkg::err_s [devctl_pkg::num_funcs-1:0] err_detect,
  input wire logic [devctl_pkg::num_funcs-1:0] snoop_suppress_bits,
  input wire logic [devctl_pkg::num_funcs-1:0] relaxed_order_disable,
  input wire logic [devctl_pkg::num_funcs-1:0] tx_relaxable,
  input wire logic [11:0] tx_len [devctl_pkg::num_funcs],
  input wire logic [11:0] rx_len [devctl_pkg::num_funcs],
  output logic aux_power_en,
  output logic [devctl_pkg::num_funcs-1:0] no_snoop_ok,
  output logic [devctl_pkg::num_funcs-1:0] relaxed_ok,
  output logic [devctl_pkg::num_funcs-1:0] tx_len_ok,
  output logic [devctl_pkg::num_funcs-1:0] rx_len_ok,
  output logic [11:0] rd_req_bytes [devctl_pkg::num_funcs],
  output devctl_pkg::err_s [devctl_pkg::num_funcs-1:0] err_msg
);
  localparam int nf = devctl_pkg::num_funcs;

  // size code to byte count; reserved codes fall back to 128
  function automatic logic [11:0] code_bytes(input logic [2:0] code);
    logic [11:0] b;
    b = devctl_pkg::bytes_128;
    if (code <= devctl_pkg::mrrs_max_code) begin
      b = 12'(devctl_pkg::bytes_128 << code);
    end
    return b;
  endfunction

  logic [15:0] ctl [nf];
  logic [15:0] next_ctl [nf];
  logic [3:0] errsts [nf];
  logic [3:0] next_errsts [nf];
  logic aux_det;
  logic [15:0] next_rdata;
  logic next_rvalid;
  logic rst_seen;
  logic next_aux_power_en;
  logic [nf-1:0] next_no_snoop_ok, next_relaxed_ok, next_tx_len_ok, next_rx_len_ok;
  logic [11:0] next_rd_req_bytes [nf];
  devctl_pkg::err_s [nf-1:0] next_err_msg;

  //////////////////////////////////////////////////////////////////////////
  // register state
  always_comb begin
    next_rdata = 16'h0000;
    next_rvalid = cfg_req.rd;
    next_aux_power_en = 1'b0;
    for (int f = 0; f < nf; f++) begin
      logic wsel;
      logic ssel;
      logic [3:0] ev;
      wsel = cfg_req.wr && (cfg_req.func == f[$clog2(nf)-1:0]);
      ssel = wsel && (cfg_req.addr == devctl_pkg::devsts_off);
      next_ctl[f] = ctl[f];
      if (!rst_seen) begin
        next_ctl[f] = devctl_pkg::ctl_rst_base;
        next_ctl[f][devctl_pkg::ctl_mrrs_hi:devctl_pkg::ctl_mrrs_lo] =
          is_lan_func[f] ? devctl_pkg::mrrs_512 : devctl_pkg::mrrs_128;
      end else if (wsel && cfg_req.addr == devctl_pkg::devctl_off) begin
        next_ctl[f] = cfg_req.wdata & devctl_pkg::ctl_wr_mask;
      end
      // ur is broadcast to all functions
      ev = {err_detect[f].ur | ur_received, err_detect[f].fatal,
            err_detect[f].nonfatal, err_detect[f].corr};
      // set wins over a simultaneous write-one clear
      next_errsts[f] = (errsts[f] & ~(ssel ? 4'(cfg_req.wdata & devctl_pkg::sts_w1c_mask) : devctl_pkg::err_none))
        | ev;
      next_aux_power_en = next_aux_power_en | ctl[f][devctl_pkg::ctl_auxpm];
      next_no_snoop_ok[f] = ctl[f][devctl_pkg::ctl_nosnoop] & ~snoop_suppress_bits[f];
      next_relaxed_ok[f] = ctl[f][devctl_pkg::ctl_relord] & ~relaxed_order_disable[f] & tx_relaxable[f];
      next_tx_len_ok[f] = tx_len[f] <= code_bytes(ctl[f][devctl_pkg::ctl_mps_hi:devctl_pkg::ctl_mps_lo]);
      next_rx_len_ok[f] = rx_len[f] <= code_bytes(ctl[f][devctl_pkg::ctl_mps_hi:devctl_pkg::ctl_mps_lo]);
      next_rd_req_bytes[f] = code_bytes(ctl[f][devctl_pkg::ctl_mrrs_hi:devctl_pkg::ctl_mrrs_lo]);
      // a clear in the same cycle must not swallow a message of another severity
      next_err_msg[f] = ev & ctl[f][devctl_pkg::ctl_ur_en:devctl_pkg::ctl_corr_en];
      if (cfg_req.rd && cfg_req.func == f[$clog2(nf)-1:0]) begin
        if (cfg_req.addr == devctl_pkg::devctl_off) begin
          next_rdata = ctl[f];
        end else if (cfg_req.addr == devctl_pkg::devsts_off) begin
          next_rdata = {10'h000, pending[f], aux_det, errsts[f]};
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_seen <= 1'b0;
      cfg_rdata <= 16'h0000;
      cfg_rvalid <= 1'b0;
      aux_power_en <= 1'b0;
      no_snoop_ok <= '0;
      relaxed_ok <= '0;
      tx_len_ok <= '0;
      rx_len_ok <= '0;
      err_msg <= '0;
      for (int f = 0; f < nf; f++) begin
        ctl[f] <= devctl_pkg::ctl_rst_base;
        errsts[f] <= devctl_pkg::err_none;
        rd_req_bytes[f] <= devctl_pkg::bytes_128;
      end
    end else begin
      // lan strap is caught on the first edge after release
      rst_seen <= 1'b1;
      cfg_rdata <= next_rdata;
      cfg_rvalid <= next_rvalid;
      aux_power_en <= next_aux_power_en;
      no_snoop_ok <= next_no_snoop_ok;
      relaxed_ok <= next_relaxed_ok;
      tx_len_ok <= next_tx_len_ok;
      rx_len_ok <= next_rx_len_ok;
      err_msg <= next_err_msg;
      for (int f = 0; f < nf; f++) begin
        ctl[f] <= next_ctl[f];
        errsts[f] <= next_errsts[f];
        rd_req_bytes[f] <= next_rd_req_bytes[f];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // aux detect: power good domain reset only
  always_ff @(posedge clk or negedge pwr_good_rst_n) begin
    if (!pwr_good_rst_n) begin
      aux_det <= 1'b0;
    end else begin
      aux_det <= aux_strap;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_ur_all;
    @(posedge clk) disable iff (!rst_n) ur_received |=> (errsts[0][3] && errsts[nf-1][3]);
  endproperty
  a_ur_all: assert property (p_ur_all) else $error("ur not seen in all functions");
  property p_w1c_hold;
    @(posedge clk) disable iff (!rst_n) (errsts[0][0] && !err_detect[0].corr &&
      !(cfg_req.wr && cfg_req.func == '0 && cfg_req.addr == devctl_pkg::devsts_off)) |=> errsts[0][0];
  endproperty
  a_w1c_hold: assert property (p_w1c_hold) else $error("error bit lost without clear");
  property p_set_wins;
    @(posedge clk) disable iff (!rst_n) err_detect[0].fatal |=> errsts[0][2];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("fatal detect lost");
  property p_msg_gate;
    @(posedge clk) disable iff (!rst_n) err_msg[0].corr |-> $past(ctl[0][devctl_pkg::ctl_corr_en]);
  endproperty
  a_msg_gate: assert property (p_msg_gate) else $error("message without enable");
  property p_rsvd;
    @(posedge clk) disable iff (!rst_n) !ctl[0][15] && !ctl[nf-1][15];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved control bit set");
  property p_sts_read;
    @(posedge clk) disable iff (!rst_n) (cfg_req.rd && cfg_req.addr == devctl_pkg::devsts_off)
      |=> (cfg_rvalid && cfg_rdata[15:6] == 10'h000);
  endproperty
  a_sts_read: assert property (p_sts_read) else $error("status read wrong");
  property p_pend;
    @(posedge clk) disable iff (!rst_n) (cfg_req.rd && cfg_req.func == '0 &&
      cfg_req.addr == devctl_pkg::devsts_off) |=> cfg_rdata[devctl_pkg::sts_trans_pend] == $past(pending[0]);
  endproperty
  a_pend: assert property (p_pend) else $error("pending bit mismatch");
  property p_aux;
    @(posedge clk) disable iff (!rst_n) ctl[0][devctl_pkg::ctl_auxpm] |=> aux_power_en;
  endproperty
  a_aux: assert property (p_aux) else $error("aux power not enabled");
  property p_tx;
    @(posedge clk) disable iff (!rst_n)
      (ctl[0][devctl_pkg::ctl_mps_hi:devctl_pkg::ctl_mps_lo] == devctl_pkg::mps_128 &&
      tx_len[0] > devctl_pkg::bytes_128) |=> !tx_len_ok[0];
  endproperty
  a_tx: assert property (p_tx) else $error("oversize tx allowed");
  // the lan-dependent read request size default is loaded on the first edge after release, not in the reset branch
  property p_lan_dflt;
    @(posedge clk) disable iff (!rst_n) !rst_seen |=> (ctl[0][devctl_pkg::ctl_mrrs_hi:devctl_pkg::ctl_mrrs_lo] ==
      ($past(is_lan_func[0]) ? devctl_pkg::mrrs_512 : devctl_pkg::mrrs_128));
  endproperty
  a_lan_dflt: assert property (p_lan_dflt) else $error("read request size default wrong");
  property p_en_dflt;
    @(posedge clk) disable iff (!rst_n) !rst_seen |=>
      (ctl[nf-1][devctl_pkg::ctl_ur_en:devctl_pkg::ctl_corr_en] == devctl_pkg::err_none &&
      !ctl[nf-1][devctl_pkg::ctl_phantom] && !ctl[nf-1][devctl_pkg::ctl_exttag]);
  endproperty
  a_en_dflt: assert property (p_en_dflt) else $error("reporting enables not cleared");
  // function reset must leave aux detect alone; only power good clears it
  property p_aux_keep;
    @(posedge clk) disable iff (!pwr_good_rst_n) pwr_good_rst_n |=> aux_det == $past(aux_strap);
  endproperty
  a_aux_keep: assert property (p_aux_keep) else $error("aux detect disturbed");
  c_wr_ctl: cover property (@(posedge clk) cfg_req.wr && cfg_req.addr == devctl_pkg::devctl_off);
  c_clear: cover property (@(posedge clk) errsts[0][1] ##1 !errsts[0][1]);
  c_msg: cover property (@(posedge clk) err_msg[0].fatal);
  c_set_wins: cover property (@(posedge clk) err_detect[0].corr && cfg_req.wr && cfg_req.addr == devctl_pkg::devsts_off);
endmodule
`default_nettype wire

// file: cfg_host_model.sv
// host configuration requester issuing one-cycle register accesses
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
  input wire logic clk,
  output var devctl_pkg::cfg_req_s cfg_req
);
  initial cfg_req = '0;
  // request held from just after one edge until just after the taking edge
  task automatic access(input logic wr, input logic [7:0] a, input logic f, input logic [15:0] d);
    if (wr && a == devctl_pkg::devctl_off && d[7:5] > 3'h1) d[7:5] = 3'h1;
    @(posedge clk);
    #2;
    cfg_req = '{wr: wr, rd: !wr, addr: a, func: f, wdata: d};
    @(posedge clk);
    #2;
    cfg_req = '0;
  endtask
endmodule
`default_nettype wire

// file: pcie_device_control_status_bench.sv
// self-checking bench for the device control and status register bank
`timescale 1ns/1ps
`default_nettype none
module pcie_device_control_status_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pwr_good_rst_n = 1'b0;
  devctl_pkg::cfg_req_s cfg_req;
  logic [15:0] cfg_rdata;
  logic cfg_rvalid, aux_power_en, aux_strap = 1'b1, ur_received = 1'b0;
  logic [1:0] is_lan_func = 2'h1, pending = 2'h1, snoop_suppress_bits = 2'h0, relaxed_order_disable = 2'h0;
  logic [1:0] tx_relaxable = 2'h3, no_snoop_ok, relaxed_ok, tx_len_ok, rx_len_ok;
  logic [11:0] tx_len [2] = '{12'h100, 12'h100};
  logic [11:0] rx_len [2] = '{12'h101, 12'h080};
  logic [11:0] rd_req_bytes [2];
  devctl_pkg::err_s [1:0] err_detect = '0;
  devctl_pkg::err_s [1:0] err_msg;
  int error_cnt = 0;
  int checked = 0;
  always #25 clk = ~clk;
  devctl_regs DUT (.clk, .rst_n, .pwr_good_rst_n, .cfg_req, .cfg_rdata, .cfg_rvalid, .is_lan_func, .pending,
    .aux_strap, .ur_received, .err_detect, .snoop_suppress_bits, .relaxed_order_disable, .tx_relaxable, .tx_len,
    .rx_len, .aux_power_en, .no_snoop_ok, .relaxed_ok, .tx_len_ok, .rx_len_ok, .rd_req_bytes, .err_msg);
  cfg_host_model host (.clk, .cfg_req);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick;
    @(posedge clk);
    #2;
  endtask
  // rvalid stands one cycle only, so it is looked at right after the taking edge
  task automatic rd(input logic [7:0] a, input logic f, input logic [15:0] exp);
    host.access(1'b0, a, f, 16'h0000);
    chk({15'h0000, cfg_rvalid}, 16'h0001);
    chk(cfg_rdata, exp);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(devctl_pkg::devctl_off, 1'b0, 16'h2810);
    rd(devctl_pkg::devctl_off, 1'b1, 16'h0810);
    rd(devctl_pkg::devsts_off, 1'b0, 16'h0030);
    rd(devctl_pkg::devsts_off, 1'b1, 16'h0010);
    rd(8'he4, 1'b0, 16'h0000);
    chk(rd_req_bytes[0], 12'h200);
    $display("test reset done");
  endtask
  task automatic t_ctl;
    host.access(1'b1, devctl_pkg::devctl_off, 1'b0, 16'hffff);
    rd(devctl_pkg::devctl_off, 1'b0, 16'h7f3f);
    chk(aux_power_en, 1'b1);
    for (int c = 0; c < 8; c++) begin
      host.access(1'b1, devctl_pkg::devctl_off, 1'b0, {1'b0, c[2:0], 12'hf3f});
      tick;
      chk(rd_req_bytes[0], c < 5 ? 12'h080 << c : 12'h080);
    end
    chk({tx_len_ok, rx_len_ok}, 16'h0006);
    chk({no_snoop_ok, relaxed_ok}, 16'h000f);
    snoop_suppress_bits = 2'h1;
    relaxed_order_disable = 2'h2;
    tick;
    tick;
    chk({no_snoop_ok, relaxed_ok}, 16'h0009);
    $display("test control done");
  endtask
  task automatic t_err;
    err_detect[1].corr = 1'b1;
    err_detect[0] = 4'h7;
    tick;
    err_detect = '0;
    chk(err_msg, 8'h07);
    ur_received = 1'b1;
    tick;
    ur_received = 1'b0;
    rd(devctl_pkg::devsts_off, 1'b1, 16'h0019);
    rd(devctl_pkg::devsts_off, 1'b0, 16'h003f);
    // detect and write-one-clear on the same edge: the set must win
    fork
      host.access(1'b1, devctl_pkg::devsts_off, 1'b0, 16'hffff);
      begin
        tick;
        err_detect[0].corr = 1'b1;
        tick;
        err_detect = '0;
      end
    join
    chk(err_msg, 8'h01);
    rd(devctl_pkg::devsts_off, 1'b0, 16'h0031);
    host.access(1'b1, devctl_pkg::devsts_off, 1'b0, 16'hffff);
    rd(devctl_pkg::devsts_off, 1'b0, 16'h0030);
    $display("test status done");
  endtask
  // function reset alone: aux detect survives, lan defaults follow the new strap
  task automatic t_fn_reset;
    rst_n = 1'b0;
    is_lan_func = 2'h2;
    tick;
    tick;
    rst_n = 1'b1;
    tick;
    chk({15'h0000, aux_power_en}, 16'h0000);
    rd(devctl_pkg::devctl_off, 1'b0, 16'h0810);
    rd(devctl_pkg::devctl_off, 1'b1, 16'h2810);
    rd(devctl_pkg::devsts_off, 1'b1, 16'h0010);
    rd(devctl_pkg::devsts_off, 1'b0, 16'h0030);
    chk(rd_req_bytes[1], 12'h200);
    $display("test function reset done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    #2;
    rst_n = 1'b1;
    pwr_good_rst_n = 1'b1;
    tick;
    t_reset;
    t_ctl;
    t_err;
    t_fn_reset;
    end_sim;
  end
  // the whole run needs well under a hundred cycles
  initial begin
    #20000;
    error_cnt++;
    end_sim;
  end
endmodule
`default_nettype wire
